// ### testbench/cmpc_analog_model.sv
// Behavioural model of the two analog comparator cores.
`timescale 1ns/1ns
module cmpc_analog_model #(
	parameter int SLOW = 3                     // Extra cycles of delay in low-power mode.
) (
	// Clock.
	input  wire logic            pclk,
	// Controls from the block.
	input  wire logic [1:0]      cmp_enable,
	input  wire logic [1:0]      cmp_speed_select,
	// Analog levels: inverting and non-inverting inputs.
	input  wire logic [1:0][7:0] vin_n,
	input  wire logic [1:0][7:0] vin_p,
	// Raw compare result to the block.
	output logic      [1:0]      cmp_raw
);
	int wait_cnt [2];                          // Low-power settling counters.

	// A powered-down core gives no usable level, so start from a known one.
	initial cmp_raw = 2'b00;

	// Each core settles to its compare result; slower when power is saved.
	always @(posedge pclk) begin
		for (int i = 0; i < 2; i++) begin
			if (!cmp_enable[i]) begin
				cmp_raw[i] <= ~cmp_raw[i];
				wait_cnt[i] <= SLOW;
			end else if (cmp_raw[i] != (vin_n[i] < vin_p[i]) && !cmp_speed_select[i]
				&& wait_cnt[i] > 0) begin
				wait_cnt[i] <= wait_cnt[i] - 1;
			end else begin
				cmp_raw[i] <= (vin_n[i] < vin_p[i]);
				wait_cnt[i] <= SLOW;
			end
		end
	end
endmodule : cmpc_analog_model

// ### testbench/cmpc_top_bench.sv
// Self-checking bench of the comparator control block.
`timescale 1ns/1ns
module cmpc_top_bench;
	import cmpc_pkg::*;

	// ------------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------------
	logic                pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
	logic [ADDR_W-1:0]   paddr;
	logic [31:0]         pwdata, prdata, rd;
	logic [1:0]          raw, sel, dir, en, spd, zlf, hys, pin, oe_n;
	logic [1:0][2:0]     pch, nch;
	logic [1:0][7:0]     vn, vp;
	logic                er;
	int                  error_cnt, total_checks, cyc;

	// Full instruction cycle, so latching only on the tick is really exercised.
	cmpc_top #(.DIV(INSTR_DIV)) u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cmp_raw_in(raw), .cmp_enable(en),
		.cmp_speed_select(spd), .cmp_zero_latency_filter(zlf), .cmp_hysteresis_en(hys),
		.cmp_pos_channel(pch), .cmp_neg_channel(nch), .peripheral_pin_select(sel),
		.pin_direction(dir), .cmp_pin_out(pin), .cmp_pin_oe_n(oe_n), .irq(irq));
	cmpc_analog_model u_model (.pclk(pclk), .cmp_enable(en), .cmp_speed_select(spd),
		.vin_n(vn), .vin_p(vp), .cmp_raw(raw));

	// Free-running 100 MHz clock.
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// A hung handshake must not stall the run forever.
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			error_cnt++;
			final_report();
		end
	end

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask : chk

	// One APB transfer; request held until pready is sampled high.
	task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
		int n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) error_cnt++;
	endtask : apb

	task automatic rchk(input logic [9:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h0);
		chk($sformatf("read of index %h", idx), rd, exp);
	endtask : rchk

	task automatic tick(input int k);
		repeat (k) @(posedge pclk);
	endtask : tick

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_reset();
		logic [9:0] idx [5] = '{IDX_CTLA1, IDX_CTLB1, IDX_CTLA2, IDX_CTLB2, IDX_RESULTS};
		logic [7:0] exp [5] = '{8'h04, 8'h00, 8'h04, 8'h00, 8'h00};
		for (int i = 0; i < 5; i++) begin
			rchk(idx[i], {24'h0, exp[i]});
		end
		chk("speed out", spd, 2'b11);
		apb(1'b0, 10'h200, 32'h0);
		chk("unmapped error", er, 1'b1);
	endtask : t_reset

	// Mode fields, channel selects and the read-only results location.
	task automatic t_fields();
		apb(1'b1, IDX_CTLA1, 32'h3F);
		rchk(IDX_CTLA1, 32'h1F);
		chk("mode outs", {zlf, hys, spd}, 6'b01_01_11);
		apb(1'b1, IDX_CTLA1, 32'h1B);
		tick(1);
		chk("speed low", spd, 2'b10);
		apb(1'b1, IDX_CTLB2, 32'hEB);
		rchk(IDX_CTLB2, 32'hEB);
		chk("channels", {pch[1], nch[1]}, 6'b101_011);
		apb(1'b1, IDX_RESULTS, 32'hFF);
		rchk(IDX_RESULTS, 32'h0);
	endtask : t_fields

	// Every input condition against both polarities, on both comparators.
	task automatic t_polarity();
		logic [9:0] a;
		logic       e;
		for (int c = 0; c < 2; c++) begin
			a = IDX_CTLA1 + 10'(c) * IDX_STRIDE;
			for (int k = 0; k < 4; k++) begin
				vp[c] <= k[0] ? 8'h28 : 8'h0A;
				apb(1'b1, a, {24'h0, 3'b100, k[1], 4'h4});
				tick(8);
				e = k[0] ^ k[1];
				rchk(a, {24'h0, 1'b1, e, 1'b0, k[1], 4'h4});
				rchk(IDX_RESULTS, 32'(e) << (c + 1));
				chk("enable out", en[c], 1'b1);
			end
			apb(1'b1, a, 32'h4);
			tick(8);
			chk("enable out", en[c], 1'b0);
			rchk(IDX_RESULTS, 32'h0);
		end
	endtask : t_polarity

	// Edge selection, masking, clear on read and a disable that must stay quiet.
	task automatic t_irq();
		vp[0] <= 8'h0A;
		apb(1'b1, IDX_CTLA1, 32'h84);
		apb(1'b1, IDX_CTLB1, 32'h80);
		apb(1'b1, IDX_IRQ_MASK, 32'h0);
		tick(8);
		apb(1'b0, IDX_IRQ_STAT, 32'h0);
		vp[0] <= 8'h28;
		tick(8);
		chk("irq masked", irq, 1'b0);
		rchk(IDX_IRQ_STAT, 32'h1);
		rchk(IDX_IRQ_STAT, 32'h0);
		apb(1'b1, IDX_IRQ_MASK, 32'h1);
		vp[0] <= 8'h0A;
		tick(8);
		rchk(IDX_IRQ_STAT, 32'h0);
		vp[0] <= 8'h28;
		tick(8);
		chk("irq", irq, 1'b1);
		rchk(IDX_IRQ_STAT, 32'h1);
		tick(2);
		chk("irq cleared", irq, 1'b0);
		apb(1'b1, IDX_CTLB1, 32'h40);
		vp[0] <= 8'h0A;
		tick(8);
		rchk(IDX_IRQ_STAT, 32'h1);
		apb(1'b1, IDX_CTLB1, 32'hC0);
		vp[0] <= 8'h28;
		tick(8);
		apb(1'b0, IDX_IRQ_STAT, 32'h0);
		apb(1'b1, IDX_CTLA1, 32'h04);
		tick(8);
		rchk(IDX_IRQ_STAT, 32'h0);
		chk("irq off", irq, 1'b0);
	endtask : t_irq

	// The pin is driven only when routed, set to output and enabled.
	task automatic t_pin();
		vp[1] <= 8'h28;
		apb(1'b1, IDX_CTLA2, 32'h80);
		sel <= 2'b10;
		dir <= 2'b00;
		tick(10);
		chk("pin enable", oe_n, 2'b01);
		chk("pin level", pin, 2'b10);
		// Synchronised mode drives the latched result, polarity included.
		apb(1'b1, IDX_CTLA2, 32'h91);
		tick(12);
		chk("pin synced inverted", pin, 2'b00);
		chk("pin synced enable", oe_n, 2'b01);
		apb(1'b1, IDX_CTLA2, 32'h81);
		tick(12);
		chk("pin synced level", pin, 2'b10);
		dir <= 2'b10;
		tick(2);
		chk("pin input dir", oe_n, 2'b11);
		dir <= 2'b00;
		apb(1'b1, IDX_CTLA2, 32'h00);
		tick(8);
		chk("pin disabled", oe_n, 2'b11);
	endtask : t_pin

	task automatic final_report();
		$display("checks %0d, mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : final_report

	// Main sequence: reset, then each scenario in turn.
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, sel, cyc} = '0;
		{error_cnt, total_checks} = '0;
		dir = 2'b11;
		vn = {8'h14, 8'h14};
		vp = {8'h0A, 8'h0A};
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_fields();
		t_polarity();
		t_irq();
		t_pin();
		final_report();
	end
endmodule : cmpc_top_bench

// ### verilog/cmpc_pkg.sv
// Constants shared by the comparator digital control block.
package cmpc_pkg;

	// ------------------------------------------------------------------
	// Bus and register map (word indices; byte address is index * 4)
	// ------------------------------------------------------------------
	localparam int         ADDR_W       = 12;            // APB address width.
	localparam int         IDX_W        = 10;            // Word index width.
	localparam int         NUM_CMP      = 2;             // Comparators served.
	localparam logic [9:0] IDX_CTLA1    = 10'h111;       // comparator1_control_a.
	localparam logic [9:0] IDX_CTLB1    = 10'h112;       // comparator1_control_b.
	localparam logic [9:0] IDX_CTLA2    = 10'h113;       // comparator2_control_a.
	localparam logic [9:0] IDX_CTLB2    = 10'h114;       // comparator2_control_b.
	localparam logic [9:0] IDX_RESULTS  = 10'h115;       // comparator_results.
	localparam logic [9:0] IDX_IRQ_STAT = 10'h11D;       // Sticky edge status.
	localparam logic [9:0] IDX_IRQ_MASK = 10'h11E;       // Interrupt mask.
	localparam logic [9:0] IDX_STRIDE   = 10'h002;       // Step between comparators.

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int A_ON   = 7;                           // cmp_enable.
	localparam int A_OUT  = 6;                           // cmp_result (read only).
	localparam int A_POL  = 4;                           // cmp_invert.
	localparam int A_ZLF  = 3;                           // cmp_zero_latency_filter.
	localparam int A_SP   = 2;                           // cmp_speed_select.
	localparam int A_HYS  = 1;                           // cmp_hysteresis_en.
	localparam int A_SYNC = 0;                           // cmp_sync_en.
	localparam int B_INTP = 7;                           // cmp_rise_irq_en.
	localparam int B_INTN = 6;                           // cmp_fall_irq_en.
	localparam int B_PCH  = 3;                           // cmp_pos_channel low bit.
	localparam int B_NCH  = 0;                           // cmp_neg_channel low bit.
	localparam int CH_W   = 3;                           // Channel select width.
	localparam int RES_LSB = 1;                          // Mirror of comparator 1.

	// ------------------------------------------------------------------
	// Reset values, write masks and timing
	// ------------------------------------------------------------------
	localparam logic [7:0] CTLA_RST   = 8'h04;           // Normal speed selected.
	localparam logic [7:0] CTLB_RST   = 8'h00;
	localparam logic [7:0] CTLA_WMASK = 8'h9F;           // Bits 6 and 5 not stored.
	localparam int         INSTR_DIV  = 4;               // Clocks per instruction cycle.

endpackage : cmpc_pkg

// ### verilog/cmpc_top.sv
// Digital control, readback and edge interrupts for two analog comparators.
//
// Local design decision: register access over APB.
`timescale 1ns/1ns
// What this block does
// - Enable bit powers comparator on or off.
// - Result readable in control and results registers.
// - Pin driven only when routed, output, enabled.
// - Internal result latched once per instruction cycle.
// - Polarity bit inverts the compare result.
// - Speed select resets to normal, zero saves power.
// - Control A holds enable, result, mode bits.
// - Control B holds edge enables, channel selects.
module cmpc_top
	import cmpc_pkg::*;
#(
	parameter int DIV = cmpc_pkg::INSTR_DIV                  // Clocks per instruction cycle.
) (
	// Clock and reset.
	input  wire logic                               pclk,
	input  wire logic                               presetn,
	// APB slave.
	input  wire logic [cmpc_pkg::ADDR_W-1:0]        paddr,
	input  wire logic                               psel,
	input  wire logic                               penable,
	input  wire logic                               pwrite,
	input  wire logic [31:0]                        pwdata,
	output logic      [31:0]                        prdata,
	output logic                                    pready,
	output logic                                    pslverr,
	// Analog cores: raw result, high when inverting input is below non-inverting.
	input  wire logic [cmpc_pkg::NUM_CMP-1:0]       cmp_raw_in,
	output logic      [cmpc_pkg::NUM_CMP-1:0]       cmp_enable,
	output logic      [cmpc_pkg::NUM_CMP-1:0]       cmp_speed_select,
	output logic      [cmpc_pkg::NUM_CMP-1:0]       cmp_zero_latency_filter,
	output logic      [cmpc_pkg::NUM_CMP-1:0]       cmp_hysteresis_en,
	output logic      [cmpc_pkg::NUM_CMP-1:0][2:0]  cmp_pos_channel,
	output logic      [cmpc_pkg::NUM_CMP-1:0][2:0]  cmp_neg_channel,
	// Pin routing: select and direction come from same-clock logic.
	input  wire logic [cmpc_pkg::NUM_CMP-1:0]       peripheral_pin_select,
	input  wire logic [cmpc_pkg::NUM_CMP-1:0]       pin_direction,
	output logic      [cmpc_pkg::NUM_CMP-1:0]       cmp_pin_out,
	output logic      [cmpc_pkg::NUM_CMP-1:0]       cmp_pin_oe_n,
	// Interrupt.
	output logic                                    irq
);
	import cmpc_pkg::*;

	localparam int DIV_W = (DIV > 1) ? $clog2(DIV) : 1;      // Divider counter width.

	// ------------------------------------------------------------------
	// Parameter check
	// ------------------------------------------------------------------
	// A divide of zero would reload the divider with 1 and give an instruction-cycle tick every 2 clocks.
	if (DIV < 1) begin : g_bad_div
		$error("cmpc_top: DIV must be at least 1");
	end

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [DIV_W-1:0]           div;       // Instruction-cycle divider.
		logic [NUM_CMP-1:0]         sync1;     // First synchroniser stage.
		logic [NUM_CMP-1:0]         sync2;     // Second synchroniser stage.
		logic [NUM_CMP-1:0][7:0]    ctla;      // Control A, result bit not stored.
		logic [NUM_CMP-1:0][7:0]    ctlb;      // Control B.
		logic [NUM_CMP-1:0]         res;       // Latched internal result.
		logic [NUM_CMP-1:0]         stat;      // Sticky edge status.
		logic [NUM_CMP-1:0]         mask;      // Interrupt mask.
		logic [NUM_CMP-1:0]         pin_out;   // Pin data.
		logic [NUM_CMP-1:0]         pin_oe_n;  // Pin enable, low drives.
		logic [31:0]                prdata;    // Read data.
		logic                       pready;    // Access-phase answer.
		logic                       pslverr;   // Unmapped address.
		logic                       irq;       // Interrupt level.
	} cmpc_state_t;

	cmpc_state_t st_ff;                        // Registered state.
	cmpc_state_t nxt_st;                       // Next state.
	logic        tick;                         // One clock per instruction cycle.
	logic        access;                       // Completing APB access.
	logic [IDX_W-1:0] idx;                     // Addressed word index.
	logic [NUM_CMP-1:0] rise_ev;               // Enabled rising edge this cycle.
	logic [NUM_CMP-1:0] fall_ev;               // Enabled falling edge this cycle.

	// ------------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------------
	// Polarity applied to a raw result.
	function automatic logic cmp_level(input logic raw, input logic [7:0] ctla);
		return raw ^ ctla[A_POL];
	endfunction : cmp_level

	// Read decode: hit flag above the data word.
	function automatic logic [32:0] read_mux(input logic [IDX_W-1:0] i, input cmpc_state_t s);
		logic [32:0] r;
		r = 33'h000000000;
		for (int c = 0; c < NUM_CMP; c++) begin
			if (i == IDX_CTLA1 + IDX_STRIDE * IDX_W'(c)) begin
				r = {1'b1, 24'h000000, s.ctla[c] | (8'(s.res[c]) << A_OUT)};
			end
			if (i == IDX_CTLB1 + IDX_STRIDE * IDX_W'(c)) begin
				r = {1'b1, 24'h000000, s.ctlb[c]};
			end
		end
		case (i)
			IDX_RESULTS:  r = {1'b1, 32'(s.res) << RES_LSB};
			IDX_IRQ_STAT: r = {1'b1, 32'(s.stat)};
			IDX_IRQ_MASK: r = {1'b1, 32'(s.mask)};
			default:      r = r;
		endcase
		return r;
	endfunction : read_mux

	// ------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------
	// Everything the block does is computed here from the registered copy.
	always_comb begin
		logic [32:0] rd;
		logic [7:0]  a;
		logic [7:0]  b;
		logic        lvl;
		logic        drive;
		logic        clr;
		rd      = 33'h000000000;
		a       = 8'h00;
		b       = 8'h00;
		lvl     = 1'b0;
		drive   = 1'b0;
		clr     = 1'b0;
		nxt_st  = st_ff;
		rise_ev = '0;
		fall_ev = '0;
		tick    = (st_ff.div == '0);
		// A refused transfer neither writes a register nor clears status.
		access  = psel & penable & st_ff.pready & ~st_ff.pslverr;
		idx     = paddr[ADDR_W-1:2];
		// Instruction-cycle divider counts down and reloads.
		nxt_st.div   = tick ? DIV_W'(DIV - 1) : st_ff.div - 1'b1;
		// The analog result is asynchronous, so two stages before use.
		nxt_st.sync1 = cmp_raw_in;
		nxt_st.sync2 = st_ff.sync1;
		// A status read clears only what the read returned, so events
		// landing between setup and access are not lost.
		clr = access & ~pwrite & (idx == IDX_IRQ_STAT);
		for (int c = 0; c < NUM_CMP; c++) begin
			a   = st_ff.ctla[c];
			b   = st_ff.ctlb[c];
			lvl = cmp_level(st_ff.sync2[c], a);
			if (!a[A_ON]) begin
				nxt_st.res[c] = 1'b0;
			end else if (tick) begin
				nxt_st.res[c] = lvl;
			end
			rise_ev[c] = a[A_ON] & ~st_ff.res[c] & nxt_st.res[c] & b[B_INTP];
			fall_ev[c] = a[A_ON] & st_ff.res[c] & ~nxt_st.res[c] & b[B_INTN];
			// Set wins over the read clear.
			nxt_st.stat[c] = (st_ff.stat[c] & ~(clr & st_ff.prdata[c]))
				| rise_ev[c] | fall_ev[c];
			drive = peripheral_pin_select[c] & ~pin_direction[c] & a[A_ON];
			nxt_st.pin_oe_n[c] = ~drive;
			// Unsynchronised mode follows the live level, not the latch.
			nxt_st.pin_out[c]  = drive & (a[A_SYNC] ? nxt_st.res[c] : lvl);
			if (access && pwrite && idx == IDX_CTLA1 + IDX_STRIDE * IDX_W'(c)) begin
				// control A write, result bit ignored
				nxt_st.ctla[c] = pwdata[7:0] & CTLA_WMASK;
			end
			if (access && pwrite && idx == IDX_CTLB1 + IDX_STRIDE * IDX_W'(c)) begin
				nxt_st.ctlb[c] = pwdata[7:0];
			end
		end
		if (access && pwrite && idx == IDX_IRQ_MASK) begin
			nxt_st.mask = pwdata[NUM_CMP-1:0];
		end
		// Setup phase captures read data; access phase answers with pready.
		nxt_st.pready  = psel & ~penable;
		nxt_st.pslverr = 1'b0;
		if (psel && !penable) begin
			rd = read_mux(idx, st_ff);
			nxt_st.pslverr = ~rd[32] | (paddr[1:0] != 2'b00);
			nxt_st.prdata  = nxt_st.pslverr ? 32'h00000000 : rd[31:0];
		end
		nxt_st.irq = |(nxt_st.stat & nxt_st.mask);
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	// Reset loads constants only.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff          <= '0;
			st_ff.pin_oe_n <= '1;
			for (int c = 0; c < NUM_CMP; c++) begin
				st_ff.ctla[c] <= CTLA_RST;
				st_ff.ctlb[c] <= CTLB_RST;
			end
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign prdata  = st_ff.prdata;
	assign pready  = st_ff.pready;
	assign pslverr = st_ff.pslverr;
	assign irq     = st_ff.irq;
	assign cmp_pin_out  = st_ff.pin_out;
	assign cmp_pin_oe_n = st_ff.pin_oe_n;
	for (genvar g = 0; g < NUM_CMP; g++) begin : g_out
		assign cmp_enable[g]              = st_ff.ctla[g][A_ON];
		assign cmp_speed_select[g]        = st_ff.ctla[g][A_SP];
		assign cmp_zero_latency_filter[g] = st_ff.ctla[g][A_ZLF];
		assign cmp_hysteresis_en[g]       = st_ff.ctla[g][A_HYS];
		assign cmp_pos_channel[g]         = st_ff.ctlb[g][B_PCH +: CH_W];
		assign cmp_neg_channel[g]         = st_ff.ctlb[g][B_NCH +: CH_W];
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// A completed, accepted write to control A of comparator 1.
	sequence s_wr_ctla1;
		psel && penable && pready && !pslverr && pwrite && paddr[ADDR_W-1:2] == IDX_CTLA1;
	endsequence
	sequence s_rise1;
		!st_ff.res[0] ##1 st_ff.res[0];
	endsequence

	a_enable_write: assert property (
		s_wr_ctla1 |=> cmp_enable[0] == $past(pwdata[A_ON]))
		else $error("enable output does not follow write");
	a_mirror_read: assert property (
		psel && penable && pready && !pwrite
		&& paddr[ADDR_W-1:2] == IDX_RESULTS && !pslverr
		|-> prdata[RES_LSB +: NUM_CMP] == $past(st_ff.res))
		else $error("results mirror mismatch");
	a_pin_gate: assert property (
		!cmp_pin_oe_n[0] |-> $past(peripheral_pin_select[0]
		&& !pin_direction[0] && cmp_enable[0]))
		else $error("pin driven without routing");
	a_latch_tick: assert property (
		$rose(st_ff.res[0]) |-> $past(tick))
		else $error("result rose off instruction tick");
	a_polarity_map: assert property (
		tick && cmp_enable[0] |=>
		st_ff.res[0] == ($past(st_ff.sync2[0]) ^ $past(st_ff.ctla[0][A_POL])))
		else $error("polarity mapping wrong");
	a_speed_write: assert property (
		s_wr_ctla1 |=> cmp_speed_select[0] == $past(pwdata[A_SP]))
		else $error("speed select does not follow write");
	a_reserved_zero: assert property (
		psel && penable && pready && !pwrite
		&& paddr[ADDR_W-1:2] == IDX_CTLA1 |-> prdata[5] == 1'b0)
		else $error("unimplemented bit reads one");
	a_chan_write: assert property (
		psel && penable && pready && !pslverr && pwrite
		&& paddr[ADDR_W-1:2] == IDX_CTLB1
		|=> cmp_pos_channel[0] == $past(pwdata[5:3]))
		else $error("channel select does not follow write");
	a_rise_flag: assert property (
		s_rise1 ##0 $past(st_ff.ctlb[0][B_INTP], 1)
		|-> st_ff.stat[0])
		else $error("rising edge did not set flag");
	a_disabled_low: assert property (
		!cmp_enable[0] |=> !st_ff.res[0] && !st_ff.stat[0]
		|| $past(st_ff.stat[0]))
		else $error("disabled comparator changed result");
	a_irq_level: assert property (
		##1 irq == |(st_ff.stat & st_ff.mask))
		else $error("interrupt level wrong");

endmodule : cmpc_top
